// *** bench/scg_clock_gate_assertions.sv ***
// port checker for the clock gating block
`timescale 1ns/1ps
module scg_clock_gate_assertions #(
  parameter int UNITS = 32
) (
  // clock and reset
  input wire logic             clk_sys_i,
  input wire logic             sys_rst_i,
  // bus handshake
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic             avs_waitrequest_o,
  // peripheral monitor
  input wire logic             periph_access_i,
  input wire logic [4:0]       periph_unit_i,
  input wire logic             periph_fault_o,
  // enables
  input wire logic [UNITS-1:0] unit_clk_en_o,
  input wire logic             comparator_one_gate_o,
  input wire logic             comparator_zero_gate_o,
  input wire logic [3:0]       gp_counter_gate_o,
  input wire logic             two_wire_one_gate_o,
  input wire logic             two_wire_zero_gate_o,
  input wire logic             sync_serial_one_gate_o,
  input wire logic             sync_serial_zero_gate_o,
  input wire logic [2:0]       async_port_gate_o,
  input wire logic             irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence seq_req;
    avs_read_i || avs_write_i;
  endsequence
  sequence seq_ack;
    !avs_waitrequest_o;
  endsequence
  sequence seq_gated_hit;
    periph_access_i && !unit_clk_en_o[periph_unit_i];
  endsequence
  ////////////////////////////////////////////////////////////////
  a_reset_state: assert property (disable iff (1'b0) sys_rst_i |=>
    unit_clk_en_o == '0 && avs_waitrequest_o && !irq_o && !periph_fault_o) else $error("reset state wrong");
  a_resv_bits_zero: assert property ((unit_clk_en_o & ~32'h030f5037) == '0)
    else $error("reserved enable bit set");
  a_fault_on_gated: assert property (seq_gated_hit |=> periph_fault_o)
    else $error("no fault on gated access");
  a_fault_only_cause: assert property (!(periph_access_i && !unit_clk_en_o[periph_unit_i]) |=> !periph_fault_o)
    else $error("fault without gated access");
  a_req_answered: assert property (seq_req |-> ##[0:4] seq_ack)
    else $error("request not answered");
  a_ack_single: assert property (seq_ack |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_comp_slices: assert property (comparator_one_gate_o == unit_clk_en_o[25]
    && comparator_zero_gate_o == unit_clk_en_o[24]) else $error("comparator enables wrong");
  a_timer_slice: assert property (gp_counter_gate_o == unit_clk_en_o[19:16])
    else $error("timer enables wrong");
  a_two_wire_slice: assert property (two_wire_one_gate_o == unit_clk_en_o[14]
    && two_wire_zero_gate_o == unit_clk_en_o[12]) else $error("two-wire enables wrong");
  a_sync_slice: assert property (sync_serial_one_gate_o == unit_clk_en_o[5]
    && sync_serial_zero_gate_o == unit_clk_en_o[4]) else $error("sync serial enables wrong");
  a_async_slice: assert property (async_port_gate_o == unit_clk_en_o[2:0])
    else $error("async port enables wrong");
endmodule : scg_clock_gate_assertions
////////////////////////////////////////////////////////////////
bind scg_clock_gate scg_clock_gate_assertions #(.UNITS(UNITS)) u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .periph_access_i(periph_access_i), .periph_unit_i(periph_unit_i),
  .periph_fault_o(periph_fault_o), .unit_clk_en_o(unit_clk_en_o),
  .comparator_one_gate_o(comparator_one_gate_o), .comparator_zero_gate_o(comparator_zero_gate_o),
  .gp_counter_gate_o(gp_counter_gate_o), .two_wire_one_gate_o(two_wire_one_gate_o),
  .two_wire_zero_gate_o(two_wire_zero_gate_o), .sync_serial_one_gate_o(sync_serial_one_gate_o),
  .sync_serial_zero_gate_o(sync_serial_zero_gate_o), .async_port_gate_o(async_port_gate_o), .irq_o(irq_o));

// *** bench/testbench.sv ***
// self-checking bench for the clock gating block
`timescale 1ns/1ps
module testbench;
  import scg_pkg::*;
  logic        clk_sys_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [11:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, unit_clk_en_o;
  logic [3:0]  avs_byteenable_i, gp_counter_gate_o;
  logic [1:0]  avs_response_o;
  logic        sleep_req_i, deep_sleep_req_i, periph_access_i, periph_fault_o, irq_o;
  logic [4:0]  periph_unit_i;
  logic        comparator_one_gate_o, comparator_zero_gate_o, two_wire_one_gate_o, two_wire_zero_gate_o;
  logic        sync_serial_one_gate_o, sync_serial_zero_gate_o;
  logic [2:0]  async_port_gate_o;
  logic [12:0] named_gates;
  int          num_errors;
  int          checks;
  assign named_gates = {comparator_one_gate_o, comparator_zero_gate_o, gp_counter_gate_o, two_wire_one_gate_o,
    two_wire_zero_gate_o, sync_serial_one_gate_o, sync_serial_zero_gate_o, async_port_gate_o};
  scg_clock_gate DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .sleep_req_i(sleep_req_i), .deep_sleep_req_i(deep_sleep_req_i), .periph_access_i(periph_access_i),
    .periph_unit_i(periph_unit_i), .periph_fault_o(periph_fault_o), .unit_clk_en_o(unit_clk_en_o),
    .comparator_one_gate_o(comparator_one_gate_o), .comparator_zero_gate_o(comparator_zero_gate_o),
    .gp_counter_gate_o(gp_counter_gate_o), .two_wire_one_gate_o(two_wire_one_gate_o),
    .two_wire_zero_gate_o(two_wire_zero_gate_o), .sync_serial_one_gate_o(sync_serial_one_gate_o),
    .sync_serial_zero_gate_o(sync_serial_zero_gate_o), .async_port_gate_o(async_port_gate_o), .irq_o(irq_o));
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask : chk
  // one avalon transfer, held until waitrequest low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic [1:0] s);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    r = avs_readdata_o;
    s = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      $display("wrong value waitrequest expected 0 seen %b", avs_waitrequest_o);
      num_errors++;
      complete_run();
    end
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic [1:0]  s;
    bus(1'b1, a, d, r, s);
    chk("write response", 32'h0, {30'h0, s});
  endtask : wr
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic [1:0]  s;
    bus(1'b0, a, 32'h0, r, s);
    chk(nm, e, r);
    chk("read response", 32'h0, {30'h0, s});
  endtask : rd_chk
  task automatic settle();
    repeat (3) @(posedge clk_sys_i);
  endtask : settle
  // single-cycle access to one unit, then the fault pulse
  task automatic touch(input logic [4:0] u, input logic e, input string nm);
    @(posedge clk_sys_i);
    periph_access_i <= 1'b1;
    periph_unit_i   <= u;
    @(posedge clk_sys_i);
    periph_access_i <= 1'b0;
    @(posedge clk_sys_i);
    chk(nm, {31'h0, e}, {31'h0, periph_fault_o});
  endtask : touch
  ////////////////////////////////////////////////////////////////
  task automatic test_reset();
    chk("enable vector", 32'h0, unit_clk_en_o);
    rd_chk("sleep register", 12'h114, 32'h0);
  endtask : test_reset
  task automatic test_modes();
    wr(12'h060, 32'h08000000);
    wr(12'h114, 32'hffffffff);
    rd_chk("sleep register", 12'h114, 32'h030f5037);
    sleep_req_i <= 1'b1;
    settle();
    chk("sleep enables", 32'h030f5037, unit_clk_en_o);
    wr(12'h114, 32'h01094016);
    settle();
    chk("sleep enables", 32'h01094016, unit_clk_en_o);
    chk("named enables", {19'h0, 13'h0cce}, {19'h0, named_gates});
    sleep_req_i <= 1'b0;
    settle();
    chk("run enables", 32'h0, unit_clk_en_o);
    wr(12'h124, 32'h00000020);
    deep_sleep_req_i <= 1'b1;
    settle();
    chk("deep enables", 32'h00000020, unit_clk_en_o);
    deep_sleep_req_i <= 1'b0;
    sleep_req_i      <= 1'b1;
    wr(12'h060, 32'h0);
    settle();
    chk("no auto gating", 32'h0, unit_clk_en_o);
    wr(12'h060, 32'h08000000);
    settle();
    chk("sleep enables", 32'h01094016, unit_clk_en_o);
    rd_chk("mode register", 12'h060, 32'h08000000);
  endtask : test_modes
  task automatic test_fault();
    wr(12'h204, 32'h1);
    touch(5'd17, 1'b1, "fault gated");
    @(posedge clk_sys_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    rd_chk("int status", 12'h200, 32'h1);
    rd_chk("fault unit", 12'h208, 32'd17);
    wr(12'h200, 32'h1);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    touch(5'd16, 1'b0, "fault clocked");
    wr(12'h204, 32'h0);
    touch(5'd0, 1'b1, "fault gated");
    settle();
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rd_chk("int status", 12'h200, 32'h1);
    wr(12'h200, 32'h1);
    rd_chk("int status", 12'h200, 32'h0);
  endtask : test_fault
  task automatic test_unmapped();
    logic [31:0] r;
    logic [1:0]  s;
    bus(1'b1, 12'h300, 32'hffffffff, r, s);
    chk("write response", 32'h3, {30'h0, s});
    bus(1'b0, 12'h300, 32'h0, r, s);
    chk("read response", 32'h3, {30'h0, s});
    chk("read data", 32'h0, r);
    rd_chk("sleep register", 12'h114, 32'h01094016);
    // read-modify-write keeps whatever the reserved bits read back
    bus(1'b0, 12'h114, 32'h0, r, s);
    wr(12'h114, r | 32'h00000020);
    rd_chk("sleep register", 12'h114, 32'h01094036);
    // only the low byte lane is written
    avs_byteenable_i <= 4'h1;
    wr(12'h114, 32'h00000000);
    avs_byteenable_i <= 4'hf;
    rd_chk("sleep register", 12'h114, 32'h01094000);
  endtask : test_unmapped
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    num_errors       = 0;
    checks           = 0;
    sys_rst_i        = 1'b1;
    avs_address_i    = 12'h0;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'hf;
    sleep_req_i      = 1'b0;
    deep_sleep_req_i = 1'b0;
    periph_access_i  = 1'b0;
    periph_unit_i    = 5'h0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    test_reset();
    test_modes();
    test_fault();
    test_unmapped();
    complete_run();
  end
endmodule : testbench

// *** common/scg_defines.svh ***
// offsets, field positions, reset values and masks of the clock gating block
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH
`define SCG_BASE_ADDR        32'h400fe000
`define SCG_RUN_OFFSET       12'h104
`define SCG_SLEEP_OFFSET     12'h114
`define SCG_DEEP_OFFSET      12'h124
`define SCG_MODE_OFFSET      12'h060
`define SCG_INT_STAT_OFFSET  12'h200
`define SCG_INT_MASK_OFFSET  12'h204
`define SCG_FAULT_OFFSET     12'h208
`define SCG_GATE_RESET       32'h00000000
`define SCG_GATE_MASK        32'h030f5037
`define SCG_AUTO_GATE_BIT    27
`define SCG_MODE_MASK        32'h08000000
`define SCG_BIT_COMPARATOR_ONE_GATE        25
`define SCG_BIT_COMPARATOR_ZERO_GATE        24
`define SCG_BIT_TIMER_HI     19
`define SCG_BIT_TIMER_LO     16
`define SCG_BIT_TW1          14
`define SCG_BIT_TW0          12
`define SCG_BIT_SS1          5
`define SCG_BIT_SS0          4
`define SCG_BIT_AP2          2
`define SCG_BIT_AP1          1
`define SCG_BIT_AP0          0
`define SCG_IRQ_FAULT_BIT    0
`define SCG_IRQ_MASK         32'h00000001
`define SCG_NUM_UNITS        32
`endif

// *** common/scg_pkg.sv ***
// types of the clock gating block
package scg_pkg;
  typedef enum logic [2:0] {
    SCG_PWR_RUN   = 3'b001,
    SCG_PWR_SLEEP = 3'b010,
    SCG_PWR_DEEP  = 3'b100
  } scg_pwr_mode_t;
  typedef enum logic [2:0] {
    SCG_BUS_IDLE  = 3'b001,
    SCG_BUS_RESP  = 3'b010,
    SCG_BUS_DONE  = 3'b100
  } scg_bus_state_t;
endpackage : scg_pkg

// *** verilog/scg_clock_gate.sv ***
// sleep mode clock gating control with run and deep sleep companions
// Operation
// RULE_01 - in sleep, each gating bit enables or disables its peripheral clock
// RULE_02 - access to a gated-off peripheral answers with a bus fault
// RULE_03 - all gating bits reset to zero, everything unclocked
// RULE_04 - sleep gating register decodes at offset 0x114 of the control region
// RULE_05 - run, sleep and deep sleep gating registers share one layout
// RULE_06 - sleep and deep sleep sets apply only with automatic gating selected
// RULE_07 - bits 25 and 24 gate comparators one and zero
// RULE_08 - bits 19 to 16 gate general purpose timers three to zero
// RULE_09 - bits 14 and 12 gate two-wire modules one and zero
// RULE_10 - bits 5 and 4 gate synchronous serial modules one and zero
// RULE_11 - bits 2, 1, 0 gate asynchronous ports two, one, zero
// RULE_12 - software keeps reserved bits on read-modify-write
// RULE_13 - software enables every unit it needs clocked in sleep
// RULE_14 - reserved bits read zero and ignore writes
`timescale 1ns/1ps
`include "scg_defines.svh"
module scg_clock_gate
  import scg_pkg::*;
#(
  parameter int UNITS = `SCG_NUM_UNITS
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // avalon-mm slave
  input  wire logic [11:0]      avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  output logic      [1:0]       avs_response_o,
  // power mode from the system
  input  wire logic             sleep_req_i,
  input  wire logic             deep_sleep_req_i,
  // peripheral access monitor
  input  wire logic             periph_access_i,
  input  wire logic [4:0]       periph_unit_i,
  output logic                  periph_fault_o,
  // gated clock enables
  output logic      [UNITS-1:0] unit_clk_en_o,
  // named enables
  output logic                  comparator_one_gate_o,
  output logic                  comparator_zero_gate_o,
  output logic      [3:0]       gp_counter_gate_o,
  output logic                  two_wire_one_gate_o,
  output logic                  two_wire_zero_gate_o,
  output logic                  sync_serial_one_gate_o,
  output logic                  sync_serial_zero_gate_o,
  output logic      [2:0]       async_port_gate_o,
  // interrupt
  output logic                  irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]    run_clock_gate_ctrl1;
  logic [31:0]    sleep_clock_gate_ctrl1;
  logic [31:0]    deep_sleep_clock_gate_ctrl1;
  logic [31:0]    run_mode_clock_config_ff;
  logic [31:0]    int_stat_ff;
  logic [31:0]    int_mask_ff;
  logic [4:0]     fault_unit_ff;
  logic [31:0]    avs_readdata_ff;
  logic           avs_waitrequest_ff;
  logic [1:0]     avs_response_ff;
  logic           periph_fault_ff;
  logic [UNITS-1:0] unit_clk_en_ff;
  logic           irq_ff;
  scg_bus_state_t bus_state_ff;
  scg_pwr_mode_t  pwr_mode;
  logic [31:0]    be_mask;
  logic [31:0]    wr_merged;
  logic           bus_req;
  logic           wr_take;
  logic           wr_run;
  logic           wr_sleep;
  logic           wr_deep;
  logic [31:0]    nxt_readdata;
  logic [1:0]     nxt_response;
  logic [31:0]    active_gate;
  logic           auto_gating_select;
  logic           fault_evt;

  ////////////////////////////////////////////////////////////////////////////
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign bus_req = (avs_read_i | avs_write_i) & (bus_state_ff == SCG_BUS_IDLE);
  assign wr_take = avs_write_i & (bus_state_ff == SCG_BUS_IDLE);
  assign wr_run   = wr_take & (avs_address_i == `SCG_RUN_OFFSET);
  assign wr_sleep = wr_take & (avs_address_i == `SCG_SLEEP_OFFSET); // RULE_04
  assign wr_deep  = wr_take & (avs_address_i == `SCG_DEEP_OFFSET);

  // three registers of one layout, byte lanes merged with the old value
  always_comb begin
    wr_merged = (avs_writedata_i & be_mask);
    if (avs_address_i == `SCG_RUN_OFFSET) begin
      wr_merged = wr_merged | (run_clock_gate_ctrl1 & ~be_mask);
    end else if (avs_address_i == `SCG_SLEEP_OFFSET) begin
      wr_merged = wr_merged | (sleep_clock_gate_ctrl1 & ~be_mask);
    end else begin
      wr_merged = wr_merged | (deep_sleep_clock_gate_ctrl1 & ~be_mask);
    end
  end

  scg_gate_reg #(.WIDTH(32), .MASK(`SCG_GATE_MASK)) u_run_gate (  // RULE_05
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_run),
    .wr_data_i (wr_merged),
    .value_o   (run_clock_gate_ctrl1)
  );

  scg_gate_reg #(.WIDTH(32), .MASK(`SCG_GATE_MASK)) u_sleep_gate (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_sleep),
    .wr_data_i (wr_merged),
    .value_o   (sleep_clock_gate_ctrl1)
  );

  scg_gate_reg #(.WIDTH(32), .MASK(`SCG_GATE_MASK)) u_deep_gate (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_deep),
    .wr_data_i (wr_merged),
    .value_o   (deep_sleep_clock_gate_ctrl1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode and interrupt registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      run_mode_clock_config_ff <= 32'h00000000;
    end else if (wr_take && avs_address_i == `SCG_MODE_OFFSET) begin
      run_mode_clock_config_ff <= (avs_writedata_i & be_mask & `SCG_MODE_MASK) |
                                  (run_mode_clock_config_ff & ~be_mask);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      int_mask_ff <= 32'h00000000;
    end else if (wr_take && avs_address_i == `SCG_INT_MASK_OFFSET) begin
      int_mask_ff <= (avs_writedata_i & be_mask & `SCG_IRQ_MASK) | (int_mask_ff & ~be_mask);
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      int_stat_ff <= 32'h00000000;
    end else begin
      int_stat_ff <= ((int_stat_ff & ~((wr_take && avs_address_i == `SCG_INT_STAT_OFFSET) ?
                       (avs_writedata_i & be_mask) : 32'h00000000)) |
                      {31'h00000000, fault_evt}) & `SCG_IRQ_MASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_stat_ff & int_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode selection and gating
  assign auto_gating_select = run_mode_clock_config_ff[`SCG_AUTO_GATE_BIT];

  always_comb begin
    if (deep_sleep_req_i) begin
      pwr_mode = SCG_PWR_DEEP;
    end else if (sleep_req_i) begin
      pwr_mode = SCG_PWR_SLEEP;
    end else begin
      pwr_mode = SCG_PWR_RUN;
    end
  end

  always_comb begin
    active_gate = run_clock_gate_ctrl1;
    case (pwr_mode)
      SCG_PWR_SLEEP: begin
        if (auto_gating_select) begin // RULE_06
          active_gate = sleep_clock_gate_ctrl1; // RULE_01
        end
      end
      SCG_PWR_DEEP: begin
        if (auto_gating_select) begin // RULE_06
          active_gate = deep_sleep_clock_gate_ctrl1;
        end
      end
      default: begin
        active_gate = run_clock_gate_ctrl1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      unit_clk_en_ff <= '0;
    end else begin
      unit_clk_en_ff <= active_gate[UNITS-1:0]; // RULE_01
    end
  end

  assign unit_clk_en_o          = unit_clk_en_ff;
  assign comparator_one_gate_o  = unit_clk_en_ff[`SCG_BIT_COMPARATOR_ONE_GATE];  // RULE_07
  assign comparator_zero_gate_o = unit_clk_en_ff[`SCG_BIT_COMPARATOR_ZERO_GATE];  // RULE_07
  assign gp_counter_gate_o      = unit_clk_en_ff[`SCG_BIT_TIMER_HI:`SCG_BIT_TIMER_LO]; // RULE_08
  assign two_wire_one_gate_o    = unit_clk_en_ff[`SCG_BIT_TW1];    // RULE_09
  assign two_wire_zero_gate_o   = unit_clk_en_ff[`SCG_BIT_TW0];    // RULE_09
  assign sync_serial_one_gate_o = unit_clk_en_ff[`SCG_BIT_SS1];    // RULE_10
  assign sync_serial_zero_gate_o = unit_clk_en_ff[`SCG_BIT_SS0];   // RULE_10
  assign async_port_gate_o      = unit_clk_en_ff[`SCG_BIT_AP2:`SCG_BIT_AP0]; // RULE_11

  ////////////////////////////////////////////////////////////////////////////
  // fault on access to an unclocked unit
  // judged against the enable the unit actually sees this cycle
  assign fault_evt = periph_access_i & ~unit_clk_en_ff[periph_unit_i]; // RULE_02

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      periph_fault_ff <= 1'b0;
    end else begin
      periph_fault_ff <= fault_evt; // RULE_02
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fault_unit_ff <= 5'h00;
    end else if (fault_evt) begin
      fault_unit_ff <= periph_unit_i;
    end
  end

  assign periph_fault_o = periph_fault_ff;
  assign irq_o          = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // avalon read decode
  always_comb begin
    nxt_response = 2'b00;
    if (avs_address_i == `SCG_RUN_OFFSET) begin
      nxt_readdata = run_clock_gate_ctrl1;
    end else if (avs_address_i == `SCG_SLEEP_OFFSET) begin
      nxt_readdata = sleep_clock_gate_ctrl1; // RULE_14
    end else if (avs_address_i == `SCG_DEEP_OFFSET) begin
      nxt_readdata = deep_sleep_clock_gate_ctrl1;
    end else if (avs_address_i == `SCG_MODE_OFFSET) begin
      nxt_readdata = run_mode_clock_config_ff;
    end else if (avs_address_i == `SCG_INT_STAT_OFFSET) begin
      nxt_readdata = int_stat_ff;
    end else if (avs_address_i == `SCG_INT_MASK_OFFSET) begin
      nxt_readdata = int_mask_ff;
    end else if (avs_address_i == `SCG_FAULT_OFFSET) begin
      nxt_readdata = {27'h0000000, fault_unit_ff};
    end else begin
      nxt_readdata = 32'h00000000;
      nxt_response = 2'b11;
    end
  end

  // one wait cycle, then completion with waitrequest low
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      bus_state_ff       <= SCG_BUS_IDLE;
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff    <= 32'h00000000;
      avs_response_ff    <= 2'b00;
    end else begin
      case (bus_state_ff)
        SCG_BUS_IDLE: begin
          if (bus_req) begin
            bus_state_ff       <= SCG_BUS_RESP;
            avs_waitrequest_ff <= 1'b0;
            avs_readdata_ff    <= avs_read_i ? nxt_readdata : 32'h00000000;
            avs_response_ff    <= nxt_response;
          end
        end
        SCG_BUS_RESP: begin
          bus_state_ff       <= SCG_BUS_DONE;
          avs_waitrequest_ff <= 1'b1;
        end
        SCG_BUS_DONE: begin
          bus_state_ff <= SCG_BUS_IDLE;
        end
        default: begin
          bus_state_ff       <= SCG_BUS_IDLE;
          avs_waitrequest_ff <= 1'b1;
        end
      endcase
    end
  end

  assign avs_readdata_o    = avs_readdata_ff;
  assign avs_waitrequest_o = avs_waitrequest_ff;
  assign avs_response_o    = avs_response_ff;
endmodule : scg_clock_gate

// *** verilog/scg_gate_reg.sv ***
// one gating register with fixed reserved bits
`timescale 1ns/1ps
`include "scg_defines.svh"
module scg_gate_reg #(
  parameter int          WIDTH = 32,
  parameter logic [31:0] MASK  = `SCG_GATE_MASK
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // write port
  input  wire logic             wr_en_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // stored value
  output logic      [WIDTH-1:0] value_o
);
  logic [WIDTH-1:0] value_ff;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      value_ff <= `SCG_GATE_RESET; // RULE_03
    end else if (wr_en_i) begin
      value_ff <= wr_data_i & MASK[WIDTH-1:0]; // RULE_14
    end
  end

  assign value_o = value_ff;
endmodule : scg_gate_reg
